// *** verilog/asff_top.sv ***
`default_nettype none

module asff_top #(
	parameter int unsigned FAULT_PULSE_CYC = asff_pkg::FAULT_PULSE_CYC_DEF
) (
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic [asff_pkg::NUM_CH-1:0] output_enable_n,
	input  wire logic [asff_pkg::NUM_CH-1:0] led_output_n,
	input  wire logic                        dim_cycle_start,
	input  wire logic [3:0]                  blank_code,
	input  wire logic [4:0]                  adc_channel_select,
	input  wire logic                        chsel_write,
	input  wire logic                        result_read,
	input  wire logic                        conv_done,
	input  wire logic [7:0]                  conv_data,
	input  wire logic                        clear_fault,
	input  wire logic                        clear_reset_flag,
	input  wire logic                        supply_low_cmp,
	input  wire logic                        supply_uv_cmp,
	input  wire logic                        ref_fault_cmp,
	input  wire logic                        lockout_cmp,
	input  wire logic [4:0]                  low_supply_threshold,
	output var  logic                        conv_start,
	output var  logic [4:0]                  conv_channel,
	output var  logic [7:0]                  adc_result,
	output var  logic                        adc_done_flag,
	output var  logic                        adc_error_flag,
	output var  logic                        reset_flag,
	output var  logic                        error_flag,
	output var  logic                        low_supply_flag,
	output var  logic                        supply_uv_flag,
	output var  logic                        ref_flag,
	output var  logic                        fault_pin_out,
	output var  logic                        fault_pin_oe,
	output var  logic                        outputs_disable,
	output var  logic                        open_short_diag_en,
	output var  logic [4:0]                  low_supply_dac_code,
	output var  logic                        por_active
);

	import asff_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic [CNT_W-1:0] blank_cycles(input logic [3:0] code);
		blank_cycles = CNT_W'((32'(code) + 32'd1) * BLANK_STEP_CYC);
	endfunction

	function automatic logic [4:0] out_code(input logic [2:0] grp, input logic [1:0] sub);
		out_code = 5'(32'(CH_OUT_BASE) + 32'(grp) * GROUP_SIZE + 32'(sub));
	endfunction

	// ==========================================
	// Pin synchronisers
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic       low_s;
	logic       uv_s;
	logic       ref_s;
	logic       lock_s;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= {lockout_cmp, ref_fault_cmp, supply_uv_cmp, supply_low_cmp};
			sync2_q <= sync1_q;
		end
	end

	assign low_s  = sync2_q[0];
	assign uv_s   = sync2_q[1];
	assign ref_s  = sync2_q[2];
	assign lock_s = sync2_q[3];

	// ==========================================
	// Sequencer decode
	asff_state_type   state_q;
	logic             auto_q;
	logic [2:0]       grp_q;
	logic [1:0]       sub_q;
	logic [4:0]       cur_ch_q;
	logic [7:0]       max_q;
	logic [7:0]       result_q;
	logic             conv_start_q;
	logic [4:0]       conv_ch_q;
	logic [CNT_W-1:0] on_cnt_q;
	logic [CNT_W-1:0] period_q;
	logic             armed_q;
	logic             done_q;
	logic             adc_err_q;
	logic [4:0]       sel_idx;
	logic             sel_en;
	logic             sel_on;
	logic             busy;
	logic             fin_evt;
	logic             done_set;
	logic             start_req;
	logic             abort;
	logic [CNT_W-1:0] min_pulse;
	logic             new_is_out;
	logic             new_en;

	assign sel_idx    = cur_ch_q - CH_OUT_BASE;
	assign sel_en     = output_enable_n[sel_idx];
	assign sel_on     = led_output_n[sel_idx];
	assign busy       = (state_q != ASFF_IDLE);
	assign min_pulse  = blank_cycles(blank_code) + CNT_W'(CONVS_PER_MEAS * CONV_CYC); // [R12]
	assign new_is_out = (adc_channel_select >= CH_OUT_BASE);
	assign new_en     = output_enable_n[5'(adc_channel_select - CH_OUT_BASE)];

	assign fin_evt   = ((state_q == ASFF_CONV) && conv_done && !auto_q)
	                 || ((state_q == ASFF_FINISH) && dim_cycle_start);
	// A completing measurement wins over a concurrent result read
	assign start_req = !lock_s && (chsel_write || (result_read && !fin_evt)); // [R9] [R10]
	assign abort     = busy && !start_req && !lock_s && dim_cycle_start && armed_q
	                 && ((period_q + CNT_W'(1)) < min_pulse); // [R13]
	assign done_set  = fin_evt && !start_req && !abort && !lock_s;

	// ==========================================
	// Sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q      <= ASFF_IDLE;
			auto_q       <= 1'b0;
			grp_q        <= 3'h0;
			sub_q        <= 2'h0;
			cur_ch_q     <= 5'h00;
			max_q        <= 8'h00;
			result_q     <= 8'h00;
			conv_start_q <= 1'b0;
			conv_ch_q    <= 5'h00;
		end else begin
			conv_start_q <= 1'b0;
			if (lock_s || abort) begin
				state_q <= ASFF_IDLE; // [R13]
			end else if (start_req) begin
				auto_q   <= (adc_channel_select == CH_SEL_MAX_OUTPUT_CHANNEL); // [R5]
				cur_ch_q <= adc_channel_select;
				grp_q    <= 3'h0;
				sub_q    <= 2'h0;
				max_q    <= 8'h00;
				if (adc_channel_select == CH_SEL_MAX_OUTPUT_CHANNEL) begin
					state_q <= ASFF_SYNC; // [R6]
				end else if (new_is_out && new_en) begin
					state_q <= ASFF_WAIT_ON; // [R1]
				end else begin
					state_q      <= ASFF_CONV; // [R3]
					conv_start_q <= 1'b1;
					conv_ch_q    <= adc_channel_select;
				end
			end else begin
				unique case (state_q)
					ASFF_IDLE: begin
					end
					ASFF_SYNC: begin
						// First full cycle after the sync edge is left unmeasured, giving nine cycles
						if (dim_cycle_start) begin
							state_q  <= ASFF_NEXT_GRP; // [R6]
							cur_ch_q <= out_code(3'h0, 2'h0);
						end
					end
					ASFF_SEL, ASFF_CONV: begin
						if ((state_q == ASFF_SEL && sel_en) ) begin
							state_q <= ASFF_WAIT_ON;
						end else if (state_q == ASFF_CONV && !conv_done) begin
							state_q <= ASFF_CONV;
						end else if (!auto_q) begin
							result_q <= conv_data;
							state_q  <= ASFF_IDLE;
						end else begin
							if (state_q == ASFF_CONV && conv_data > max_q) begin
								max_q <= conv_data; // [R5]
							end
							// Disabled channels fall through here unmeasured
							if (sub_q == 2'(GROUP_SIZE - 1)) begin // [R11] [R7]
								sub_q <= 2'h0;
								if (grp_q == 3'(NUM_GROUPS - 1)) begin
									state_q <= ASFF_FINISH;
								end else begin
									grp_q    <= grp_q + 3'h1;
									cur_ch_q <= out_code(grp_q + 3'h1, 2'h0);
									state_q  <= ASFF_NEXT_GRP;
								end
							end else begin
								sub_q    <= sub_q + 2'h1;
								cur_ch_q <= out_code(grp_q, sub_q + 2'h1);
								state_q  <= ASFF_SEL;
							end
						end
					end
					ASFF_WAIT_ON: begin
						if (!sel_en || on_cnt_q >= blank_cycles(blank_code)) begin // [R1] [R3]
							state_q      <= ASFF_CONV;
							conv_start_q <= 1'b1;
							conv_ch_q    <= cur_ch_q;
						end
					end
					ASFF_NEXT_GRP: begin
						if (dim_cycle_start) begin
							state_q <= ASFF_SEL; // [R7]
						end
					end
					ASFF_FINISH: begin
						if (dim_cycle_start) begin
							result_q <= max_q; // [R8]
							state_q  <= ASFF_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ==========================================
	// Blanking counter: on-time of the selected output
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			on_cnt_q <= '0;
		end else if (state_q != ASFF_WAIT_ON || !sel_on) begin
			on_cnt_q <= '0;
		end else if (on_cnt_q != '1) begin
			on_cnt_q <= on_cnt_q + CNT_W'(1); // [R1]
		end
	end

	// ==========================================
	// Dimming period monitor
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			armed_q  <= 1'b0;
			period_q <= '0;
		end else if (start_req || !busy) begin
			armed_q  <= 1'b0;
			period_q <= '0;
		end else if (dim_cycle_start) begin
			armed_q  <= 1'b1; // [R12]
			period_q <= '0;
		end else if (period_q != '1) begin
			period_q <= period_q + CNT_W'(1);
		end
	end

	// ==========================================
	// ADC flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_q <= 1'b0;
		end else if (done_set) begin
			done_q <= 1'b1; // [R8]
		end else if (start_req || lock_s) begin
			done_q <= 1'b0; // [R9] [R10]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			adc_err_q <= 1'b0;
		end else begin
			adc_err_q <= abort || (adc_err_q && !clear_fault); // [R13] [R14] [R23]
		end
	end

	// ==========================================
	// Fault flags
	logic lock_prev_q;
	logic reset_flag_q;
	logic error_flag_q;
	logic low_flag_q;
	logic uv_flag_q;
	logic ref_flag_q;
	logic low_prev_q;
	logic low_pulse;
	logic [4:0] dac_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_prev_q <= 1'b0;
			low_prev_q  <= 1'b0;
		end else begin
			lock_prev_q <= lock_s;
			low_prev_q  <= low_s;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reset_flag_q <= RESET_FLAG_RST;
		end else begin
			reset_flag_q <= lock_s || lock_prev_q || (reset_flag_q && !clear_reset_flag); // [R16] [R17] [R23]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_flag_q <= 1'b0;
			uv_flag_q  <= 1'b0;
			ref_flag_q <= 1'b0;
		end else begin
			low_flag_q <= low_s || (low_flag_q && !clear_fault); // [R18] [R19] [R23]
			uv_flag_q  <= uv_s  || (uv_flag_q  && !clear_fault); // [R21]
			ref_flag_q <= ref_s || (ref_flag_q && !clear_fault); // [R22]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			error_flag_q <= ERROR_FLAG_RST;
		end else begin
			error_flag_q <= low_s || uv_s || ref_s || lock_s || lock_prev_q
			             || (error_flag_q && !clear_fault && !clear_reset_flag); // [R16] [R17] [R19]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dac_q <= 5'h00;
		end else begin
			dac_q <= low_supply_threshold; // [R20]
		end
	end

	asff_pulse_timer #(
		.CYCLES (FAULT_PULSE_CYC)
	) u_low_pulse (
		.clk     (clk),
		.rst_b   (rst_b),
		.trigger (low_s && !low_prev_q), // [R18]
		.active  (low_pulse)
	);

	// ==========================================
	// Outputs
	assign conv_start          = conv_start_q;
	assign conv_channel        = conv_ch_q;
	assign adc_result          = result_q;
	assign adc_done_flag       = done_q;
	assign adc_error_flag      = adc_err_q;
	assign reset_flag          = reset_flag_q;
	assign error_flag          = error_flag_q;
	assign low_supply_flag     = low_flag_q;
	assign supply_uv_flag      = uv_flag_q;
	assign ref_flag            = ref_flag_q;
	assign fault_pin_out       = 1'b0;
	assign fault_pin_oe        = low_pulse || uv_s || ref_s; // [R18] [R21] [R22] [R15]
	assign outputs_disable     = uv_s; // [R21] [R15]
	assign open_short_diag_en  = !low_s; // [R20]
	assign low_supply_dac_code = dac_q;
	assign por_active          = lock_s; // [R16]

endmodule

`default_nettype wire

// *** common/asff_pkg.sv ***
// Functional notes
// [R1] Enabled output sampled after blanking delay from turn-on
// [R2] Controller keeps on-pulse above blank plus three conversions
// [R3] Disabled selected output sampled in off state
// [R4] Controller forces full duty when period too short
// [R5] Select 06h runs auto scan, stores maximum
// [R6] Auto scan result only after nine dimming cycles
// [R7] Three channels per group, one group per cycle
// [R8] After eight groups set done, halt scan
// [R9] Result read clears done, restarts scan
// [R10] Select write clears done and restarts conversion
// [R11] Auto scan skips disabled outputs
// [R12] While converting, compare period to blank plus conversions
// [R13] Short dimming period aborts conversion, sets error
// [R14] Clear-fault clears ADC error flag
// [R15] Only lockout, undervoltage act; others just report
// [R16] Lockout recovery sets reset and error flags
// [R17] Clear-reset clears reset and error flags
// [R18] Low supply pulses fault pin, sets flags
// [R19] Low-supply flags latched until clear-fault
// [R20] Open/short diagnosis enabled only above threshold
// [R21] Undervoltage holds pin, sets flags, disables outputs
// [R22] Reference fault holds pin while present, flags latched
// [R23] Clear bits self-clear; zero writes do nothing
`default_nettype none

package asff_pkg;

	// ==========================================
	// Channel map
	localparam int unsigned NUM_CH        = 24;
	localparam int unsigned NUM_GROUPS    = 8;
	localparam int unsigned GROUP_SIZE    = 3;
	localparam logic [4:0]  CH_SEL_MAX_OUTPUT_CHANNEL = 5'h06;
	localparam logic [4:0]  CH_OUT_BASE   = 5'h08;

	// ==========================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 5;
	localparam int unsigned CONV_TIME_NS   = 1000;
	localparam int unsigned BLANK_STEP_NS  = 500;
	localparam int unsigned FAULT_PULSE_US = 50;
	localparam int unsigned CONV_CYC       = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BLANK_STEP_CYC = (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FAULT_PULSE_CYC_DEF = (FAULT_PULSE_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned CONVS_PER_MEAS = 3;

	// ==========================================
	// Counter widths and reset values
	localparam int unsigned CNT_W          = 16;
	localparam logic        RESET_FLAG_RST = 1'b1;
	localparam logic        ERROR_FLAG_RST = 1'b1;

	typedef enum logic [2:0] {
		ASFF_IDLE,
		ASFF_SYNC,
		ASFF_SEL,
		ASFF_WAIT_ON,
		ASFF_CONV,
		ASFF_NEXT_GRP,
		ASFF_FINISH
	} asff_state_type;

endpackage

`default_nettype wire

// *** verilog/asff_pulse_timer.sv ***
`default_nettype none

module asff_pulse_timer #(
	parameter int unsigned CYCLES = 10000
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic trigger,
	output var  logic active
);

	localparam int unsigned W = $clog2(CYCLES + 1);

	logic [W-1:0] cnt_q;
	logic         active_q;

	// Retrigger restarts the full pulse length
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q    <= '0;
			active_q <= 1'b0;
		end else if (trigger) begin
			cnt_q    <= W'(CYCLES - 1);
			active_q <= 1'b1;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end else begin
			active_q <= 1'b0;
		end
	end

	assign active = active_q;

endmodule

`default_nettype wire

// *** verification/asff_conv_model.sv ***
`default_nettype none

module asff_conv_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       conv_start,
	input  wire logic [4:0] conv_channel,
	input  wire logic [7:0] salt,
	input  wire logic [31:0] lat,
	output var  logic       conv_done,
	output var  logic [7:0] conv_data
);
	timeunit 1ns;
	timeprecision 1ps;

	int         cnt;
	logic [7:0] val;

	// ==========================================
	// Converter: answers lat cycles after a start, a new start aborts the old one
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt = 0;
			conv_done <= 1'b0;
			conv_data <= 8'h00;
		end else begin
			conv_done <= 1'b0;
			// Data line is not held outside the done cycle
			conv_data <= ~conv_data;
			if (conv_start) begin
				cnt = lat;
				val = {conv_channel, 3'h0} ^ salt;
			end else if (cnt > 0) begin
				cnt--;
				if (cnt == 0) begin
					conv_done <= 1'b1;
					conv_data <= val;
				end
			end
		end
	end
endmodule

`default_nettype wire

// *** verification/asff_top_props.sv ***
`default_nettype none

module asff_props #(
	parameter int unsigned FAULT_PULSE_CYC = 20
) (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       chsel_write,
	input wire logic       result_read,
	input wire logic       conv_done,
	input wire logic       dim_cycle_start,
	input wire logic [4:0] adc_channel_select,
	input wire logic       clear_fault,
	input wire logic       clear_reset_flag,
	input wire logic       conv_start,
	input wire logic [4:0] conv_channel,
	input wire logic       adc_done_flag,
	input wire logic       adc_error_flag,
	input wire logic       reset_flag,
	input wire logic       ref_flag,
	input wire logic       low_supply_flag,
	input wire logic       supply_uv_flag,
	input wire logic       error_flag,
	input wire logic       fault_pin_oe,
	input wire logic       outputs_disable,
	input wire logic       open_short_diag_en,
	input wire logic       por_active
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	int unsigned oe_run;

	// ==========================================
	// Length of a pulsed fault pin run
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			oe_run <= 0;
		end else begin
			oe_run <= (fault_pin_oe && !outputs_disable && !ref_flag) ? oe_run + 1 : 0;
		end
	end

	sequence low_rise;
		$fell(open_short_diag_en);
	endsequence
	sequence pin_pulse;
		fault_pin_oe [*8];
	endsequence

	chk_manual_start: assert property (chsel_write && !por_active && (adc_channel_select < 5'h06
		|| adc_channel_select == 5'h07) |=> conv_start && conv_channel == $past(adc_channel_select))
		else $error("no prompt start after select write");
	chk_done_clear: assert property (chsel_write && !por_active |=> !adc_done_flag)
		else $error("done flag survived select write");
	chk_read_clear: assert property (result_read && !conv_done && !dim_cycle_start |=> !adc_done_flag)
		else $error("done flag survived result read");
	chk_adcerr_clear: assert property (clear_fault && !dim_cycle_start |=> !adc_error_flag)
		else $error("adc error flag not cleared");
	chk_reset_clear: assert property (clear_reset_flag && !por_active && !$past(por_active) |=> !reset_flag)
		else $error("reset flag not cleared");
	chk_uv_flags: assert property (outputs_disable |=> supply_uv_flag && error_flag)
		else $error("undervoltage flags not set");
	chk_uv_pin: assert property (outputs_disable |-> fault_pin_oe)
		else $error("fault pin not held during undervoltage");
	chk_low_pulse: assert property (low_rise |=> pin_pulse)
		else $error("low supply pulse missing");
	chk_low_flags: assert property (low_rise |=> low_supply_flag && error_flag)
		else $error("low supply flags not set");
	chk_pulse_len: assert property (oe_run <= FAULT_PULSE_CYC)
		else $error("fault pin pulse too long");
endmodule

bind asff_top asff_props #(.FAULT_PULSE_CYC(FAULT_PULSE_CYC)) asff_props_i (.*);

`default_nettype wire

// *** verification/tb_adc_sequencer_and_fault_flags.sv ***
`default_nettype none

module tb_adc_sequencer_and_fault_flags;
	timeunit 1ns;
	timeprecision 1ps;
	import asff_pkg::*;

	logic        clk, rst_b, dim_cycle_start, chsel_write, result_read, conv_done, conv_start;
	logic        clear_fault, clear_reset_flag, supply_low_cmp, supply_uv_cmp, ref_fault_cmp, lockout_cmp;
	logic        adc_done_flag, adc_error_flag, reset_flag, error_flag, low_supply_flag, supply_uv_flag;
	logic        ref_flag, fault_pin_out, fault_pin_oe, outputs_disable, open_short_diag_en, por_active;
	logic [23:0] output_enable_n, led_output_n;
	logic [7:0]  conv_data, adc_result, salt, mx;
	logic [4:0]  adc_channel_select, conv_channel, low_supply_threshold, low_supply_dac_code;
	logic [3:0]  blank_code;
	logic [4:0]  man_ch [9];
	logic        dim_on;
	int          err_total, tests_run, lat, period, dcnt, dims, d0, n;

	asff_top #(.FAULT_PULSE_CYC(20)) asff_top_i (.*);
	asff_conv_model asff_conv_model_i (.*);

	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	// Dimming cycle start pulses, driven on the edge by non-blocking assignment
	always @(posedge clk) begin
		dim_cycle_start <= 1'b0;
		if (dim_on && ++dcnt >= period) begin
			dcnt = 0;
			dims++;
			dim_cycle_start <= 1'b1;
		end
	end

	task automatic cyc(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic strobe(int k);
		{clear_reset_flag, clear_fault, result_read} = 3'b001 << k;
		cyc(1);
		{clear_reset_flag, clear_fault, result_read} = 3'b000;
	endtask

	task automatic write_sel(logic [4:0] s);
		adc_channel_select = s;
		chsel_write = 1;
		cyc(1);
		chsel_write = 0;
	endtask

	task automatic wait_done(int bound);
		for (int i = 0; i < bound && adc_done_flag !== 1'b1; i++) cyc(1);
		if (adc_done_flag !== 1'b1) begin
			err_total++;
			complete_run();
		end
	endtask

	function automatic logic [7:0] exp_data(logic [4:0] ch);
		return {ch, 3'h0} ^ salt;
	endfunction

	task automatic hold_fault(int k);
		{ref_fault_cmp, supply_uv_cmp} = 2'b01 << k;
		cyc(5);
		check("pin held", fault_pin_oe, 1);
		check("pin level", fault_pin_out, 0);
		check("flag set", k ? ref_flag : supply_uv_flag, 1);
		check("outputs off", outputs_disable, !k);
		{ref_fault_cmp, supply_uv_cmp} = 2'b00;
		cyc(5);
		check("pin released", fault_pin_oe, 0);
		check("flag latched", k ? ref_flag : supply_uv_flag, 1);
		strobe(1);
		check("flag cleared", {k ? ref_flag : supply_uv_flag, error_flag}, 0);
	endtask

	initial begin
		{rst_b, dim_on, chsel_write, result_read, clear_fault, clear_reset_flag} = 0;
		{supply_low_cmp, supply_uv_cmp, ref_fault_cmp, lockout_cmp, blank_code} = 0;
		{dcnt, dims, err_total, tests_run} = 0;
		output_enable_n = '1;
		led_output_n = '1;
		adc_channel_select = 5'h00;
		salt = 8'($urandom(32'hd50df4f1));
		low_supply_threshold = 5'($urandom_range(31));
		lat = 5;
		period = 1000;
		repeat (12) @(posedge clk);
		#1 rst_b = 1;
		cyc(4);
		check("reset flag", {reset_flag, error_flag}, 2'b11);
		check("dac code", low_supply_dac_code, low_supply_threshold);
		strobe(2);
		check("reset cleared", {reset_flag, error_flag}, 0);

		// ==========================================
		// Manual conversions, channel 09h disabled and read in off state
		output_enable_n[1] = 0;
		man_ch = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h09};
		blank_code = 4'($urandom_range(15));
		foreach (man_ch[i]) begin
			lat = (i % 2) ? 120 : 5;
			write_sel(man_ch[i]);
			wait_done(2000);
			check("manual result", adc_result, exp_data(adc_channel_select));
			strobe(0);
			check("done after read", adc_done_flag, 0);
			wait_done(2000);
			check("reread result", adc_result, exp_data(adc_channel_select));
		end

		// ==========================================
		// Auto scan over random enables; maximum of enabled outputs only
		output_enable_n = 24'($urandom()) | 24'h800000;
		mx = 8'h00;
		for (int c = 0; c < 24; c++) if (output_enable_n[c] && exp_data(5'(c + 8)) > mx) mx = exp_data(5'(c + 8));
		lat = 60;
		blank_code = 4'h0;
		dim_on = 1;
		for (int r = 0; r < 2; r++) begin
			if (r == 0) write_sel(CH_SEL_MAX_OUTPUT_CHANNEL);
			else strobe(0);
			// A cycle pulse launched at the start edge is still ahead of the design
			d0 = dims - int'(dim_cycle_start);
			for (int i = 0; i < 12000 && dims - d0 < 10; i++) cyc(1);
			check("scan cycles", 8'(dims - d0), 8'h0a);
			check("done early", adc_done_flag, 0);
			wait_done(1500);
			check("scan max", adc_result, mx);
		end

		// ==========================================
		// Dimming period shorter than blank plus three conversions
		period = 300;
		write_sel(CH_SEL_MAX_OUTPUT_CHANNEL);
		for (int i = 0; i < 3000 && adc_error_flag !== 1'b1; i++) cyc(1);
		check("adc error", {adc_error_flag, adc_done_flag}, 2'b10);
		dim_on = 0;
		cyc(2);
		strobe(1);
		check("adc error clear", adc_error_flag, 0);

		// ==========================================
		// Low supply warning
		supply_low_cmp = 1;
		n = 0;
		repeat (60) begin
			cyc(1);
			n += fault_pin_oe;
		end
		check("pulse length", 8'(n), 8'd20);
		check("diag gated", {low_supply_flag, error_flag, open_short_diag_en}, 3'b110);
		strobe(1);
		check("low latched", low_supply_flag, 1);
		supply_low_cmp = 0;
		cyc(5);
		strobe(1);
		check("low cleared", {low_supply_flag, error_flag, open_short_diag_en}, 3'b001);

		hold_fault(0);
		hold_fault(1);

		// ==========================================
		// Lockout and recovery
		lockout_cmp = 1;
		cyc(5);
		check("lockout", {por_active, reset_flag}, 2'b11);
		lockout_cmp = 0;
		cyc(5);
		check("recovered", {por_active, reset_flag, error_flag}, 3'b011);
		strobe(2);
		check("reset clear", {reset_flag, error_flag}, 0);
		complete_run();
	end
endmodule

`default_nettype wire
